// file: clamp_learn_seq.sv
// One channel's load-learning pass: settle, then capture the load code.
// Assumes load_code has been synchronised and is stable after settling.
`timescale 1ns/10ps
module clamp_learn_seq
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic start,
   input wire logic abort,
   input wire logic [3:0] load_code,
   output logic busy,
   output logic done,
   output logic [3:0] learned
);
   typedef enum logic [1:0] {L_IDLE = 2'h0, L_SETTLE = 2'h1,
      L_DONE = 2'h3} learn_st_t;
   learn_st_t st_ff, nxt_st;
   logic [11:0] cnt_ff;
   logic [3:0] lvl_ff;
   wire settled = cnt_ff ==
      supply_clamp_pkg::LEARN_CW'(supply_clamp_pkg::LEARN_CYC - 1);
   // A new start restarts the pass even while one is running.
   always_comb
   begin
      nxt_st = st_ff;
      case (st_ff)
         L_IDLE: nxt_st = start ? L_SETTLE : L_IDLE;
         L_SETTLE: nxt_st = settled ? L_DONE : L_SETTLE;
         L_DONE: nxt_st = L_IDLE;
         default: nxt_st = L_IDLE;
      endcase
      if (start)
         nxt_st = L_SETTLE;
      else if (abort)
         nxt_st = L_IDLE;
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_ff <= L_IDLE;
         cnt_ff <= 12'h000;
         lvl_ff <= 4'h0;
      end
      else
      begin
         st_ff <= nxt_st;
         cnt_ff <= (st_ff == L_SETTLE && !start) ? cnt_ff + 12'h001 : 12'h000;
         if (st_ff == L_SETTLE && settled)
            lvl_ff <= load_code;
      end
   end
   assign busy = st_ff == L_SETTLE;
   assign done = st_ff == L_DONE;
   assign learned = lvl_ff;
endmodule

// file: spi_host_model.sv
// Host side of the serial register port: one 24-bit frame per call.
// Assumes mclk is the device clock; sclk half period is 5 mclk cycles.
`timescale 1ns/10ps
module spi_host_model
(
   input wire logic mclk,
   input wire logic spi_sdo,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdi
);
   initial
   begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
   end

   // Bits go out MSB first and read data is taken on each of the last 16 sclk rises.
   // The data line is inverted once the frame ends.
   // A stale bit must never pass for a driven one.
   task automatic xfer(input logic [23:0] frm, output logic [15:0] rd);
      int i;
      rd = 16'h0000;
      @(negedge mclk);
      spi_cs_n = 1'b0;
      for (i = 23; i >= 0; i--)
      begin
         spi_sdi = frm[i];
         repeat (5) @(negedge mclk);
         spi_sclk = 1'b1;
         if (i < 16)
            rd[i] = spi_sdo;
         repeat (5) @(negedge mclk);
         spi_sclk = 1'b0;
      end
      repeat (5) @(negedge mclk);
      spi_cs_n = 1'b1;
      spi_sdi = ~spi_sdi;
      repeat (8) @(negedge mclk);
   endtask
endmodule

// file: spi_reg_port.sv
// Serial register port: 24-bit frames, read flag, 7-bit address, data.
// Assumes pins come from outside the mclk domain; sclk is far slower.
`timescale 1ns/10ps
module spi_reg_port
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   output logic wr_en,
   output logic rd_en,
   output logic [6:0] reg_addr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   logic [2:0] s1_ff, s2_ff;
   logic sclk_old_ff, cs_old_ff, rd_ff, hdr_ff;
   logic [4:0] cnt_ff;
   logic [23:0] sh_ff;
   logic [15:0] tx_ff;
   wire sclk_rise = s2_ff[0] & ~sclk_old_ff;
   wire sclk_fall = ~s2_ff[0] & sclk_old_ff;
   wire cs_act = ~s2_ff[1];
   wire cs_end = s2_ff[1] & ~cs_old_ff;
   wire [23:0] nxt_sh = {sh_ff[22:0], s2_ff[2]};
   wire hdr_done = sclk_rise & cs_act
      & (cnt_ff == 5'(supply_clamp_pkg::FRAME_HDR_BITS - 1));
   wire frame_full = cnt_ff == 5'(supply_clamp_pkg::FRAME_BITS);
   // Two-flop synchronisers for all three pins.
   always_ff @(posedge mclk)
   begin
      s1_ff <= {spi_sdi, spi_cs_n, spi_sclk};
      s2_ff <= s1_ff;
      sclk_old_ff <= s2_ff[0];
      cs_old_ff <= s2_ff[1];
   end
   // Shift in on rising sclk, shift readback out on falling sclk.
   always_ff @(posedge mclk)
   begin
      if (rst | ~cs_act)
      begin
         cnt_ff <= 5'h0;
         sh_ff <= 24'h00_0000;
         hdr_ff <= 1'b0;
      end
      else
      begin
         // One-cycle pulse once the eighth header bit is in.
         hdr_ff <= hdr_done;
         if (sclk_rise)
         begin
            sh_ff <= nxt_sh;
            cnt_ff <= cnt_ff + 5'h1;
         end
      end
   end
   // Readback data is fetched once the header is in, same frame.
   // The fall right after the header keeps the MSB for the next rise.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         tx_ff <= 16'h0000;
         rd_ff <= 1'b0;
      end
      else if (rd_en)
      begin
         tx_ff <= reg_rdata;
         rd_ff <= 1'b1;
      end
      else if (cs_end)
         rd_ff <= 1'b0;
      else if (sclk_fall & rd_ff
         & (cnt_ff > 5'(supply_clamp_pkg::FRAME_HDR_BITS)))
         tx_ff <= {tx_ff[14:0], 1'b0};
   end
   assign rd_en = hdr_ff & sh_ff[supply_clamp_pkg::FRAME_HDR_BITS - 1];
   assign wr_en = cs_end & frame_full & ~sh_ff[supply_clamp_pkg::FRAME_RD_BIT];
   assign reg_addr = hdr_ff ? sh_ff[6:0]
      : sh_ff[supply_clamp_pkg::FRAME_ADDR_HI:supply_clamp_pkg::FRAME_ADDR_LO];
   assign reg_wdata = sh_ff[15:0];
   assign spi_sdo = tx_ff[15];
   assign spi_sdo_oe = rd_ff & cs_act;
endmodule

// file: supply_clamp_ctrl.sv
// Converter selection, arm enable and supply target control for four
// buck-boost channels, reached over the serial register port.
// Assumes analog status pins are asynchronous and are synchronised here.
// Function
// - Any converter mix selected via 0x06.
// - Arms enabled independently per 0x07 write.
// - Disabled negative arm ties input to ground.
// - Voltage mode targets 15 V unless clamped.
// - Current mode: negative rail only bipolar 24mA or open with both arms.
// - Clamp mode resets to tracking, 4 V floor.
// - Tracking keeps headroom at most 3 V.
// - Mode 01 uses clamp fields as floors.
// - Mode 10 learns load, fixes positive floor.
// - Learn end stores level, sets done flag.
// - Positive clamp field read-only while learning.
// - Every write of 10 restarts learning.
// - Limit bit lowers maximum from 32 to 26 V.
// - Limit applies to channels selected at 0x03.
// - Open current output with positive arm forces fixed rail pairs.
// - Status stays set until written one or learning restarts.
`timescale 1ns/10ps
module supply_clamp_ctrl
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   input wire logic [3:0] chan_current_mode,
   input wire logic [3:0] chan_bipolar_24ma,
   input wire logic [3:0] iout_open,
   input wire logic [3:0] iout_negative,
   input wire logic [15:0] learn_load_code,
   output logic [3:0] pos_arm_on,
   output logic [3:0] neg_arm_on,
   output logic [3:0] neg_to_pgnd,
   output logic [3:0] track_en,
   output logic [63:0] pos_target_mv,
   output logic [63:0] neg_target_mv,
   output logic [63:0] pos_max_mv
);
   localparam int N = supply_clamp_pkg::NCH;

   // Register port wires.
   logic wr_en, rd_en;
   logic [6:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;

   // Stored configuration.
   logic [15:0] chan_sel_ff, conv_sel_ff;
   logic [5:0] alarm_code_ff;
   logic [N-1:0] pos_en_ff, neg_en_ff, hs_lim_ff, learn_done_ff;
   supply_clamp_pkg::clamp_mode_t mode_ff [N];
   logic [3:0] pclamp_ff [N];
   logic [3:0] nclamp_ff [N];

   // Synchronised analog status.
   logic [3:0] cm_s1, cm_s2, bp_s1, bp_s2, op_s1, op_s2, ng_s1, ng_s2;
   logic [15:0] ld_s1, ld_s2;

   // Learn sequencer handshakes.
   logic [N-1:0] learn_start, learn_abort, learn_busy, learn_end;
   logic [3:0] learned [N];

   spi_reg_port u_port
   (
      .mclk(mclk),
      .rst(rst),
      .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo),
      .spi_sdo_oe(spi_sdo_oe),
      .wr_en(wr_en),
      .rd_en(rd_en),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata)
   );

   // Address decode of the five registers.
   wire wr_chan = wr_en & (reg_addr == supply_clamp_pkg::ADDR_CHAN_SEL);
   wire wr_conv = wr_en & (reg_addr == supply_clamp_pkg::ADDR_CONV_SEL);
   wire wr_arm = wr_en & (reg_addr == supply_clamp_pkg::ADDR_ARM_CLAMP);
   wire wr_stat = wr_en & (reg_addr == supply_clamp_pkg::ADDR_STATUS);
   wire wr_lim = wr_en & (reg_addr == supply_clamp_pkg::ADDR_ALARM_LIMIT);

   // Fields of a write to the arm and clamp register.
   wire w_pos = reg_wdata[supply_clamp_pkg::ARM_POS_BIT];
   wire w_neg = reg_wdata[supply_clamp_pkg::ARM_NEG_BIT];
   wire [1:0] w_mode = reg_wdata[supply_clamp_pkg::CMODE_LO +: 2];
   wire [3:0] w_pcl = reg_wdata[supply_clamp_pkg::PCLAMP_LO +: 4];
   wire [3:0] w_ncl = reg_wdata[supply_clamp_pkg::NCLAMP_LO +: 4];
   wire w_learn = w_mode == supply_clamp_pkg::CMODE_LEARN;

   // Readback of the arm and clamp register shows the lowest
   // selected converter, since one address covers all four.
   logic [1:0] rb_ch;
   logic hs_lim_sel_view;
   always_comb
   begin
      rb_ch = 2'h0;
      for (int i = N - 1; i >= 0; i--)
         if (conv_sel_ff[i])
            rb_ch = 2'(i);
   end
   wire [15:0] arm_rb = {4'h0, nclamp_ff[rb_ch], pclamp_ff[rb_ch],
      mode_ff[rb_ch], neg_en_ff[rb_ch], pos_en_ff[rb_ch]};

   // Read multiplexer; unmapped addresses read as zero.
   always_comb
   begin
      case (reg_addr)
         supply_clamp_pkg::ADDR_CHAN_SEL: reg_rdata = chan_sel_ff;
         supply_clamp_pkg::ADDR_CONV_SEL: reg_rdata = conv_sel_ff;
         supply_clamp_pkg::ADDR_ARM_CLAMP: reg_rdata = arm_rb;
         supply_clamp_pkg::ADDR_STATUS: reg_rdata = {12'h000, learn_done_ff};
         supply_clamp_pkg::ADDR_ALARM_LIMIT:
            reg_rdata = {9'h000, 1'b0, alarm_code_ff} |
               (16'(hs_lim_sel_view) << supply_clamp_pkg::HS_LIMIT_BIT);
         default: reg_rdata = 16'h0000;
      endcase
   end

   // The limit bit reads back from the lowest channel selected at 0x03.
   always_comb
   begin
      hs_lim_sel_view = 1'b0;
      for (int i = N - 1; i >= 0; i--)
         if (chan_sel_ff[i])
            hs_lim_sel_view = hs_lim_ff[i];
   end

   // Analog status pins cross in through two flops each.
   always_ff @(posedge mclk)
   begin
      cm_s1 <= chan_current_mode;
      bp_s1 <= chan_bipolar_24ma;
      op_s1 <= iout_open;
      ng_s1 <= iout_negative;
      ld_s1 <= learn_load_code;
      cm_s2 <= cm_s1;
      bp_s2 <= bp_s1;
      op_s2 <= op_s1;
      ng_s2 <= ng_s1;
      ld_s2 <= ld_s1;
   end

   // Selection registers and the alarm code field.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         chan_sel_ff <= 16'h0000;
         conv_sel_ff <= 16'h0000;
         alarm_code_ff <= 6'h00;
      end
      else
      begin
         if (wr_chan)
            chan_sel_ff <= reg_wdata;
         if (wr_conv)
            conv_sel_ff <= reg_wdata;
         if (wr_lim)
            alarm_code_ff <= reg_wdata[supply_clamp_pkg::ALARM_CODE_W-1:0];
      end
   end

   // Per-channel configuration and learn hookup.
   for (genvar c = 0; c < N; c++)
   begin : g_ch
      wire sel = conv_sel_ff[c] & wr_arm;
      // Learning starts on every 10 write, even a repeat; the host has
      // already put the channel in tracking with a code loaded.
      assign learn_start[c] = sel & w_learn;
      assign learn_abort[c] = sel & ~w_learn &
         (w_mode != supply_clamp_pkg::CMODE_RSVD);

      clamp_learn_seq u_learn
      (
         .mclk(mclk),
         .rst(rst),
         .start(learn_start[c]),
         .abort(learn_abort[c]),
         .load_code(ld_s2[4*c +: 4]),
         .busy(learn_busy[c]),
         .done(learn_end[c]),
         .learned(learned[c])
      );

      always_ff @(posedge mclk)
      begin
         if (rst)
         begin
            pos_en_ff[c] <= 1'b0;
            neg_en_ff[c] <= 1'b0;
            mode_ff[c] <= supply_clamp_pkg::CMODE_TRACK;
            pclamp_ff[c] <= 4'h0;
            nclamp_ff[c] <= 4'h0;
         end
         else
         begin
            if (sel)
            begin
               pos_en_ff[c] <= w_pos;
               neg_en_ff[c] <= w_neg;
               nclamp_ff[c] <= w_ncl;
               if (w_mode != supply_clamp_pkg::CMODE_RSVD)
                  mode_ff[c] <= supply_clamp_pkg::clamp_mode_t'(w_mode);
               // A write that itself leaves learn mode may set the field.
               if (mode_ff[c] != supply_clamp_pkg::CMODE_LEARN
                  || learn_abort[c])
                  pclamp_ff[c] <= w_pcl;
            end
            if (learn_end[c])
               pclamp_ff[c] <= learned[c];
         end
      end

      // Done flag: hardware set beats a same-cycle write-one clear.
      always_ff @(posedge mclk)
      begin
         if (rst)
            learn_done_ff[c] <= 1'b0;
         else if (learn_end[c])
            learn_done_ff[c] <= 1'b1;
         else if (wr_stat & reg_wdata[c])
            learn_done_ff[c] <= 1'b0;
         else if (learn_start[c])
            learn_done_ff[c] <= 1'b0;
      end

      // High-side limit goes only to channels selected at 0x03.
      always_ff @(posedge mclk)
      begin
         if (rst)
            hs_lim_ff[c] <= 1'b0;
         else if (wr_lim & chan_sel_ff[c])
            hs_lim_ff[c] <= reg_wdata[supply_clamp_pkg::HS_LIMIT_BIT];
      end

      // Supply targets; registered so the power stage sees clean words.
      logic [15:0] nxt_pos, nxt_neg, nxt_max;
      logic nxt_track;
      logic [15:0] pos_ff, neg_ff, max_ff;
      logic track_ff;
      always_comb
      begin
         nxt_track = 1'b0;
         nxt_max = hs_lim_ff[c] ? supply_clamp_pkg::POS_LIMIT_MV
            : supply_clamp_pkg::POS_MAX_MV;
         if (!cm_s2[c])
         begin
            // Voltage output: fixed rails unless clamp mode 01 overrides.
            nxt_pos = supply_clamp_pkg::VOUT_RAIL_MV;
            nxt_neg = supply_clamp_pkg::VOUT_RAIL_MV;
            if (mode_ff[c] == supply_clamp_pkg::CMODE_FIXED)
            begin
               nxt_pos = clamp_mv(pclamp_ff[c]);
               nxt_neg = clamp_mv(nclamp_ff[c]);
            end
         end
         else if (op_s2[c] && pos_en_ff[c] && neg_en_ff[c])
         begin
            // Open output with both arms: rails depend on pin sign.
            if (bp_s2[c] && ng_s2[c])
            begin
               nxt_pos = supply_clamp_pkg::OPEN_POS_LO_MV;
               nxt_neg = supply_clamp_pkg::OPEN_NEG_HI_MV;
            end
            else
            begin
               nxt_pos = supply_clamp_pkg::OPEN_POS_HI_MV;
               nxt_neg = supply_clamp_pkg::OPEN_NEG_LO_MV;
            end
         end
         else if (op_s2[c] && pos_en_ff[c])
         begin
            nxt_pos = supply_clamp_pkg::POS_MAX_MV;
            nxt_neg = supply_clamp_pkg::ZERO_MV;
         end
         else
         begin
            // Current output: floor per clamp mode, tracking above it in mode 00 or while learning.
            nxt_track = mode_ff[c] == supply_clamp_pkg::CMODE_TRACK;
            case (mode_ff[c])
               supply_clamp_pkg::CMODE_FIXED:
                  nxt_pos = clamp_mv(pclamp_ff[c]);
               supply_clamp_pkg::CMODE_LEARN:
                  nxt_pos = learn_busy[c] ? supply_clamp_pkg::TRACK_FLOOR_MV
                     : clamp_mv(pclamp_ff[c]);
               default:
                  nxt_pos = supply_clamp_pkg::TRACK_FLOOR_MV;
            endcase
            nxt_track = nxt_track | learn_busy[c];
            nxt_neg = !bp_s2[c] ? supply_clamp_pkg::ZERO_MV
               : (mode_ff[c] == supply_clamp_pkg::CMODE_FIXED)
               ? clamp_mv(nclamp_ff[c])
               : supply_clamp_pkg::HEADROOM_MV;
         end
         if (!neg_en_ff[c])
            nxt_neg = supply_clamp_pkg::ZERO_MV;
         if (nxt_pos > nxt_max)
            nxt_pos = nxt_max;
      end

      always_ff @(posedge mclk)
      begin
         if (rst)
         begin
            pos_ff <= supply_clamp_pkg::ZERO_MV;
            neg_ff <= supply_clamp_pkg::ZERO_MV;
            max_ff <= supply_clamp_pkg::POS_MAX_MV;
            track_ff <= 1'b0;
         end
         else
         begin
            pos_ff <= nxt_pos;
            neg_ff <= nxt_neg;
            max_ff <= nxt_max;
            track_ff <= nxt_track & pos_en_ff[c];
         end
      end

      assign pos_target_mv[16*c +: 16] = pos_ff;
      assign neg_target_mv[16*c +: 16] = neg_ff;
      assign pos_max_mv[16*c +: 16] = max_ff;
      assign track_en[c] = track_ff;
      // Negative rail runs only for voltage, a bipolar range or an open output with both arms.
      assign neg_arm_on[c] = neg_en_ff[c] & (~cm_s2[c] | bp_s2[c]
         | (op_s2[c] & pos_en_ff[c]));
   end

   assign pos_arm_on = pos_en_ff;
   assign neg_to_pgnd = ~neg_en_ff;

   // Clamp code to floor voltage, used for both arms in mode 01 and the positive arm in mode 10.
   function automatic logic [15:0] clamp_mv(input logic [3:0] code);
      logic [19:0] prod;
      prod = 20'(code) * 20'(supply_clamp_pkg::CLAMP_STEP_MV);
      return supply_clamp_pkg::CLAMP_BASE_MV + prod[15:0];
   endfunction
endmodule

// file: supply_clamp_ctrl_asserts.sv
// Checker for the converter supply control block, bound to its ports.
// Assumes the single mclk domain and its synchronous reset rst.
`timescale 1ns/10ps
module supply_clamp_asserts
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic spi_cs_n,
   input wire logic spi_sdo_oe,
   input wire logic [3:0] chan_current_mode,
   input wire logic [3:0] iout_open,
   input wire logic [3:0] iout_negative,
   input wire logic [3:0] pos_arm_on,
   input wire logic [3:0] neg_arm_on,
   input wire logic [3:0] neg_to_pgnd,
   input wire logic [63:0] pos_target_mv,
   input wire logic [63:0] neg_target_mv,
   input wire logic [63:0] pos_max_mv
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   // Ground tie and the running negative arm exclude each other.
   AST_NEG_EXCL: assert property (!(neg_arm_on & neg_to_pgnd))
      else $error("negative arm runs while tied to ground");
   AST_RESET_STATE: assert property (disable iff (1'b0)
      rst |=> pos_arm_on == 4'h0 && neg_to_pgnd == 4'hf
      && pos_max_mv == {4{16'h7d00}} && pos_target_mv == {4{16'h0000}})
      else $error("outputs not at reset values");
   AST_MAX_LEGAL: assert property (
      pos_max_mv[15:0] inside {16'h7d00, 16'h6590}
      && pos_max_mv[47:32] inside {16'h7d00, 16'h6590})
      else $error("positive maximum not 32 V or 26 V");
   AST_POS_BOUND: assert property (
      pos_target_mv[15:0] <= 16'h7d00 && pos_target_mv[31:16] <= 16'h7d00)
      else $error("positive target above 32 V");
   AST_NEG_OFF: assert property (
      neg_to_pgnd[1] [*2] |-> neg_target_mv[31:16] == 16'h0000)
      else $error("negative target while arm is off");
   // Pins pass a two-stage synchroniser, so six quiet cycles suffice.
   AST_OPEN_BOTH: assert property (
      (chan_current_mode[3] && iout_open[3] && !iout_negative[3]
      && pos_arm_on[3] && !neg_to_pgnd[3]) [*6]
      |-> pos_target_mv[63:48] == 16'h4e20
      && neg_target_mv[63:48] == 16'h1388)
      else $error("open output rails wrong with both arms");
   AST_OPEN_POS: assert property (
      (chan_current_mode[0] && iout_open[0] && !iout_negative[0]
      && pos_arm_on[0] && neg_to_pgnd[0] && $stable(pos_max_mv)) [*6]
      |-> pos_target_mv[15:0] == pos_max_mv[15:0]
      && neg_target_mv[15:0] == 16'h0000)
      else $error("open output rails wrong with positive arm only");
   AST_CFG_AT_IDLE: assert property (
      (!$stable(pos_arm_on) || !$stable(pos_max_mv)) |-> spi_cs_n)
      else $error("configuration changed inside a frame");
   AST_OE_IDLE: assert property (spi_cs_n [*5] |-> !spi_sdo_oe)
      else $error("readback driven without a frame");
   AST_OE_RISE: assert property ($rose(spi_sdo_oe) |-> !spi_cs_n)
      else $error("readback enabled while deselected");
endmodule

// file: supply_clamp_pkg.sv
// Constants shared by the converter supply and clamp control design.
// Assumes a 50 MHz device clock and a four-channel output device.
package supply_clamp_pkg;
   localparam int NCH = 4;
   // Register addresses of the serial register port.
   localparam logic [6:0] ADDR_CHAN_SEL = 7'h03;
   localparam logic [6:0] ADDR_CONV_SEL = 7'h06;
   localparam logic [6:0] ADDR_ARM_CLAMP = 7'h07;
   localparam logic [6:0] ADDR_STATUS = 7'h0b;
   localparam logic [6:0] ADDR_ALARM_LIMIT = 7'h0e;
   // Serial frame layout: read flag, address, data.
   localparam int FRAME_BITS = 24;
   localparam int FRAME_RD_BIT = 23;
   localparam int FRAME_ADDR_HI = 22;
   localparam int FRAME_ADDR_LO = 16;
   localparam int FRAME_HDR_BITS = 8;
   // Field positions in the arm and clamp register.
   localparam int ARM_POS_BIT = 0;
   localparam int ARM_NEG_BIT = 1;
   localparam int CMODE_LO = 2;
   localparam int PCLAMP_LO = 4;
   localparam int NCLAMP_LO = 8;
   // Field positions in the alarm code and limit register.
   localparam int ALARM_CODE_W = 6;
   localparam int HS_LIMIT_BIT = 6;
   // Clamp-mode selector encodings.
   typedef enum logic [1:0]
   {
      CMODE_TRACK = 2'h0,
      CMODE_FIXED = 2'h1,
      CMODE_LEARN = 2'h2,
      CMODE_RSVD = 2'h3
   } clamp_mode_t;
   // Supply figures in millivolts.
   localparam logic [15:0] VOUT_RAIL_MV = 16'h3a_98;
   localparam logic [15:0] TRACK_FLOOR_MV = 16'h0f_a0;
   localparam logic [15:0] HEADROOM_MV = 16'h0b_b8;
   localparam logic [15:0] POS_MAX_MV = 16'h7d_00;
   localparam logic [15:0] POS_LIMIT_MV = 16'h65_90;
   localparam logic [15:0] OPEN_POS_HI_MV = 16'h4e_20;
   localparam logic [15:0] OPEN_NEG_LO_MV = 16'h13_88;
   localparam logic [15:0] OPEN_POS_LO_MV = 16'h0f_a0;
   localparam logic [15:0] OPEN_NEG_HI_MV = 16'h4e_20;
   localparam logic [15:0] ZERO_MV = 16'h00_00;
   // Clamp code to millivolt mapping; plain defaults.
   localparam logic [15:0] CLAMP_BASE_MV = 16'h0f_a0;
   localparam logic [15:0] CLAMP_STEP_MV = 16'h07_d0;
   // Learn settle time and its cycle count.
   localparam int CLK_MHZ = 50;
   localparam int LEARN_SETTLE_US = 50;
   localparam int LEARN_CYC = LEARN_SETTLE_US * CLK_MHZ;
   localparam int LEARN_CW = 12;
endpackage

// file: tb.sv
// Self-checking bench for the converter supply control block.
// Assumes the design files and the host model are compiled before it.
`timescale 1ns/10ps
module tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
   logic [3:0] chan_current_mode, chan_bipolar_24ma, iout_open;
   logic [3:0] iout_negative, pos_arm_on, neg_arm_on, neg_to_pgnd;
   logic [3:0] track_en;
   logic [15:0] learn_load_code, rv;
   logic [63:0] pos_target_mv, neg_target_mv, pos_max_mv;
   int miscompares = 0;
   int n_checks = 0;
   int k;

   always #10 mclk = ~mclk;

   supply_clamp_ctrl supply_clamp_ctrl_inst (.mclk(mclk), .rst(rst),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
      .chan_current_mode(chan_current_mode),
      .chan_bipolar_24ma(chan_bipolar_24ma), .iout_open(iout_open),
      .iout_negative(iout_negative), .learn_load_code(learn_load_code),
      .pos_arm_on(pos_arm_on), .neg_arm_on(neg_arm_on),
      .neg_to_pgnd(neg_to_pgnd), .track_en(track_en),
      .pos_target_mv(pos_target_mv), .neg_target_mv(neg_target_mv),
      .pos_max_mv(pos_max_mv));

   spi_host_model spi_host_model_inst (.mclk(mclk), .spi_sdo(spi_sdo),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi));

   // Comparison, register access and the closing report.
   task automatic chk(input string nm, input logic [63:0] got, exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] x;
      spi_host_model_inst.xfer({1'b0, a, d}, x);
   endtask
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      spi_host_model_inst.xfer({1'b1, a, 16'h0000}, d);
   endtask
   task automatic rdchk(input string nm, input logic [6:0] a,
      input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      chk(nm, d, e);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Main sequence; inputs only move on the falling edge.
   initial
   begin
      chan_current_mode = 4'h0;
      chan_bipolar_24ma = 4'h0;
      iout_open = 4'h0;
      iout_negative = 4'h0;
      learn_load_code = 16'h0000;
      repeat (10) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      chk("pos_arm_on", pos_arm_on, 4'h0);
      chk("neg_to_pgnd", neg_to_pgnd, 4'hf);
      chk("pos_max", pos_max_mv, {4{16'h7d00}});
      rdchk("arm_clamp", 7'h07, 16'h0000);
      $display("test reset done");
      wr(7'h06, 16'h0005);
      wr(7'h07, 16'h0001);
      chk("pos_arm_on", pos_arm_on, 4'h5);
      chk("neg_to_pgnd", neg_to_pgnd, 4'hf);
      wr(7'h06, 16'h000a);
      wr(7'h07, 16'h0003);
      chk("pos_arm_on", pos_arm_on, 4'hf);
      chk("neg_to_pgnd", neg_to_pgnd, 4'h5);
      chk("neg_arm_on", neg_arm_on, 4'ha);
      rdchk("conv_sel", 7'h06, 16'h000a);
      rdchk("arm_clamp", 7'h07, 16'h0003);
      chk("pos_v1", pos_target_mv[31:16], 16'h3a98);
      chk("neg_v1", neg_target_mv[31:16], 16'h3a98);
      chk("neg_v0", neg_target_mv[15:0], 16'h0000);
      $display("test select and arms done");
      wr(7'h07, 16'h0237);
      chk("pos_c1", pos_target_mv[31:16], 16'h2710);
      chk("neg_c1", neg_target_mv[31:16], 16'h1f40);
      wr(7'h07, 16'h023f);
      rdchk("arm_clamp", 7'h07, 16'h0237);
      chk("pos_c1", pos_target_mv[31:16], 16'h2710);
      $display("test clamp modes done");
      wr(7'h03, 16'h0004);
      wr(7'h0e, 16'h0040);
      chk("pos_max", pos_max_mv, {16'h7d00, 16'h6590, {2{16'h7d00}}});
      rdchk("alarm_lim", 7'h0e, 16'h0040);
      wr(7'h10, 16'hffff);
      rdchk("unmapped", 7'h10, 16'h0000);
      rdchk("conv_sel", 7'h06, 16'h000a);
      $display("test limit done");
      @(negedge mclk);
      chan_current_mode = 4'hf;
      chan_bipolar_24ma = 4'h2;
      wr(7'h07, 16'h0003);
      chk("track_en", track_en & 4'ha, 4'ha);
      chk("pos_t1", pos_target_mv[31:16], 16'h0fa0);
      chk("neg_t1", neg_target_mv[31:16], 16'h0bb8);
      chk("neg_t3", neg_target_mv[63:48], 16'h0000);
      chk("neg_arm_on", neg_arm_on & 4'ha, 4'h2);
      $display("test current mode done");
      iout_open = 4'hf;
      iout_negative = 4'h2;
      repeat (8) @(negedge mclk);
      chk("pos_open", pos_target_mv, 64'h4e20_6590_0fa0_7d00);
      chk("neg_open", neg_target_mv, 64'h1388_0000_4e20_0000);
      iout_open = 4'h0;
      iout_negative = 4'h0;
      $display("test open output done");
      // Host prepares tracking, current output and a load code first.
      wr(7'h06, 16'h0002);
      learn_load_code = 16'h0050;
      wr(7'h07, 16'h000b);
      repeat (1500) @(negedge mclk);
      wr(7'h07, 16'h00fb);
      repeat (1500) @(negedge mclk);
      rdchk("status", 7'h0b, 16'h0000);
      k = 0;
      rv = 16'h0000;
      while (rv[1] !== 1'b1 && k < 10)
      begin
         rd(7'h0b, rv);
         k++;
      end
      if (rv[1] !== 1'b1)
         miscompares++;
      rdchk("arm_clamp", 7'h07, 16'h005b);
      rdchk("status", 7'h0b, 16'h0002);
      wr(7'h0b, 16'h0000);
      rdchk("status", 7'h0b, 16'h0002);
      wr(7'h0b, 16'h0002);
      rdchk("status", 7'h0b, 16'h0000);
      $display("test learn done");
      complete_run();
   end
endmodule

bind supply_clamp_ctrl supply_clamp_asserts supply_clamp_asserts_inst (
   .mclk(mclk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
   .chan_current_mode(chan_current_mode), .iout_open(iout_open),
   .iout_negative(iout_negative), .pos_arm_on(pos_arm_on),
   .neg_arm_on(neg_arm_on), .neg_to_pgnd(neg_to_pgnd),
   .pos_target_mv(pos_target_mv), .neg_target_mv(neg_target_mv),
   .pos_max_mv(pos_max_mv));
